// file: epr_pkg.sv
package epr_pkg;
    // register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_LINE  = 8'h04;
    localparam logic [7:0] A_RXCFG = 8'h08;
    localparam logic [7:0] A_MACLO = 8'h0C;
    localparam logic [7:0] A_MACHI = 8'h10;
    localparam logic [7:0] A_IP    = 8'h14;
    localparam logic [7:0] A_VLAN  = 8'h18;
    localparam logic [7:0] A_PWD   = 8'h1C;
    localparam logic [7:0] A_STAT  = 8'h20;
    localparam logic [7:0] A_PRE   = 8'h24;
    localparam logic [7:0] A_IFG   = 8'h28;
    localparam logic [7:0] A_OVS   = 8'h2C;
    localparam logic [7:0] A_QUANT = 8'h30;
    // control bit positions
    localparam int C_PAUSE = 0;
    localparam int C_ECHO  = 1;
    localparam int C_NS    = 2;
    localparam int C_ARP   = 3;
    localparam int C_PING  = 4;
    localparam int C_LF    = 5;
    localparam int C_IGPRE = 6;
    localparam int C_IFGF  = 7;
    localparam int C_RFAN  = 8;
    localparam int C_IB    = 9;
    localparam int C_VLAN  = 10;
    localparam int C_STRM  = 11;
    localparam int C_DMAC  = 12;
    localparam int C_W     = 13;
    // line rate codes
    localparam logic [2:0] R_10M  = 3'h0;
    localparam logic [2:0] R_100M = 3'h1;
    localparam logic [2:0] R_1G   = 3'h2;
    localparam logic [2:0] R_10GL = 3'h3;
    localparam logic [2:0] R_10GW = 3'h4;
    localparam logic [2:0] R_25G  = 3'h5;
    localparam logic [2:0] R_40G  = 3'h6;
    localparam logic [2:0] R_100G = 3'h7;
    // receiver limits and reset values
    localparam logic [3:0]  PRE_DEF = 4'h8;
    localparam logic [3:0]  PRE_MIN = 4'h3;
    localparam logic [3:0]  PRE_MAX = 4'hF;
    localparam logic [3:0]  IFG_DEF = 4'hC;
    localparam logic [3:0]  IFG_MIN = 4'h8;
    localparam logic [3:0]  IFG_MAX = 4'hF;
    localparam logic [13:0] JMB_DEF = 14'd9018;
    localparam logic [13:0] JMB_MIN = 14'd1519;
    localparam logic [13:0] JMB_MAX = 14'd16000;
    // in-band header constants
    localparam logic [7:0]  IB_TOS  = 8'h00;
    localparam logic [7:0]  IB_TTL  = 8'd20;
    localparam logic [15:0] IB_TPID = 16'h8100;
    localparam logic [2:0]  IB_PCP  = 3'h0;
    localparam logic [3:0]  PWD_MIN = 4'h4;
    localparam logic [3:0]  PWD_MAX = 4'h8;
    // 512 bit times at 1 Gb/s over a 20 ns clock
    localparam logic [15:0] QNT_DEF = 16'd26;
    localparam logic [47:0] MAC_DEF = 48'h0;

    typedef enum logic [1:0] {RK_ECHO, RK_ARP, RK_NS} epr_kind_t;
    typedef enum logic [1:0] {TX_IDLE, TX_STREAM, TX_RFAULT} epr_txm_t;

    typedef struct packed {
        logic        pause;
        logic [15:0] quanta;
        logic        echo;
        logic        arp;
        logic        ns;
    } epr_rx_ev_t;

    typedef struct packed {
        logic pre;
        logic dat;
        logic idle;
    } epr_rx_byte_t;

    typedef struct packed {
        logic        valid;
        epr_kind_t   kind;
        logic [47:0] mac;
        logic [31:0] ip;
    } epr_reply_t;

    typedef struct packed {
        logic        en;
        logic        vlan_en;
        logic [15:0] tpid;
        logic [2:0]  pcp;
        logic        dei;
        logic [11:0] vid;
        logic [7:0]  tos;
        logic [7:0]  ttl;
        logic [47:0] mac;
        logic [31:0] ip;
    } epr_inband_t;
endpackage

// file: epr_rx_check.sv
`timescale 1ns/1ps
`default_nettype none
module epr_rx_check (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // settings
    input  wire logic                  chk_en,
    input  wire logic                  ign_pre,
    input  wire logic                  ifg_hide,
    input  wire logic [3:0]            pre_len,
    input  wire logic [3:0]            ifg_min,
    input  wire logic [13:0]           jumbo,
    // byte stream
    input  wire epr_pkg::epr_rx_byte_t rx,
    // violation pulses
    output logic                       pre_viol,
    output logic                       ifg_viol,
    output logic                       oversize
);
    import epr_pkg::*;

    logic [4:0]  pre_cnt_ff;
    logic [4:0]  ifg_cnt_ff;
    logic [13:0] len_ff;
    logic        in_pre_ff;
    logic        in_dat_ff;
    logic        seen_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_cnt_ff <= 5'h0;
            in_pre_ff  <= 1'b0;
        end else if (rx.pre) begin
            pre_cnt_ff <= in_pre_ff ? pre_cnt_ff + ((pre_cnt_ff == 5'h1F) ? 5'h0 : 5'h1) : 5'h1;
            in_pre_ff  <= 1'b1;
        end else if (rx.dat | rx.idle) begin
            in_pre_ff  <= 1'b0;
        end
    end

    // gap measured in idle bytes; the first frame after reset has no gap to judge
    always_ff @(posedge clock) begin
        if (rst) begin
            ifg_cnt_ff <= 5'h0;
            seen_ff    <= 1'b0;
        end else if (rx.idle) begin
            ifg_cnt_ff <= (ifg_cnt_ff == 5'h1F) ? ifg_cnt_ff : ifg_cnt_ff + 5'h1;
        end else if (rx.pre && !in_pre_ff) begin
            ifg_cnt_ff <= 5'h0;
            seen_ff    <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            len_ff    <= 14'h0;
            in_dat_ff <= 1'b0;
        end else if (rx.dat) begin
            len_ff    <= in_dat_ff ? len_ff + ((len_ff == 14'h3FFF) ? 14'h0 : 14'h1) : 14'h1;
            in_dat_ff <= 1'b1;
        end else if (rx.idle | rx.pre) begin
            in_dat_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pre_viol <= 1'b0;
            ifg_viol <= 1'b0;
            oversize <= 1'b0;
        end else begin
            pre_viol <= chk_en && rx.dat && in_pre_ff && !ign_pre
                        && pre_cnt_ff != {1'b0, pre_len};
            ifg_viol <= chk_en && rx.pre && !in_pre_ff && seen_ff && !ifg_hide
                        && ifg_cnt_ff < {1'b0, ifg_min};
            oversize <= (rx.idle | rx.pre) && in_dat_ff && len_ff > jumbo;
        end
    end
endmodule // epr_rx_check
`default_nettype wire

// file: epr_port.sv
`timescale 1ns/1ps
`default_nettype none
module epr_port (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // receive side, from the frame parser and pcs
    input  wire epr_pkg::epr_rx_ev_t   rx_ev,
    input  wire epr_pkg::epr_rx_byte_t rx_byte,
    input  wire logic                  rx_local_fault,
    input  wire logic                  rx_remote_fault,
    input  wire logic                  an_lp_remote_fault,
    // port identity and neighbour ports
    input  wire logic [47:0]           hw_mac,
    input  wire logic                  inband_taken_other,
    // transmit control
    output logic                       tx_halt,
    output epr_pkg::epr_txm_t          tx_mode,
    output epr_pkg::epr_reply_t        reply,
    // in-band control channel setup and link partner fault status
    output epr_pkg::epr_inband_t       inband,
    output logic                       inband_owned,
    output logic                       lp_remote_fault
);
    import epr_pkg::*;

    logic [C_W-1:0]  ctrl_ff;
    logic [2:0]      rate_ff;
    logic            an_mode_ff;
    logic            if_ok_ff;
    logic [3:0]      pre_len_ff;
    logic [3:0]      ifg_min_ff;
    logic [13:0]     jumbo_ff;
    logic [47:0]     mac_ff;
    logic [31:0]     ip_ff;
    logic [11:0]     vid_ff;
    logic [3:0]      pwd_len_ff;
    logic            pwd_on_ff;
    logic [15:0]     quant_ff;
    logic [15:0]     pre_cnt_ff;
    logic [15:0]     ifg_cnt_ff;
    logic [15:0]     ovs_cnt_ff;
    logic [15:0]     qtick_ff;
    logic [15:0]     pause_left_ff;
    epr_txm_t        nxt_mode;
    logic            wr;
    logic            rd;
    logic            hit;
    logic            fast;
    logic            chk_en;
    logic            ib_ok;
    logic            pre_viol;
    logic            ifg_viol;
    logic            oversize;
    logic            force_rep;
    logic [31:0]     rdat;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h1;
    endfunction

    function automatic logic in_rng4(input logic [3:0] v, input logic [3:0] lo,
                                     input logic [3:0] hi);
        in_rng4 = v >= lo && v <= hi;
    endfunction

    // pready answers in the second access cycle; writes land there, reads fetch a cycle early
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && penable && !pwrite && !pready;

    assign fast   = rate_ff >= R_10GL;
    assign chk_en = rate_ff <= R_10GW;
    assign ib_ok  = rate_ff != R_10GW && !inband_taken_other;
    assign force_rep = ctrl_ff[C_PING];

    // ---- register writes ----
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= '0;
        end else if (wr && paddr == A_CTRL) begin
            ctrl_ff <= pwdata[C_W-1:0];
            // refused when another port already holds the channel
            ctrl_ff[C_IB] <= pwdata[C_IB] && ib_ok;
        end else if (!ib_ok) begin
            ctrl_ff[C_IB] <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rate_ff    <= R_1G;
            an_mode_ff <= 1'b0;
            if_ok_ff   <= 1'b0;
        end else if (wr && paddr == A_LINE) begin
            rate_ff    <= pwdata[2:0];
            an_mode_ff <= pwdata[4];
            if_ok_ff   <= pwdata[5];
        end
    end

    // out-of-range limits are dropped and the old value kept
    always_ff @(posedge clock) begin
        if (rst) begin
            pre_len_ff <= PRE_DEF;
            ifg_min_ff <= IFG_DEF;
            jumbo_ff   <= JMB_DEF;
        end else if (wr && paddr == A_RXCFG) begin
            if (in_rng4(pwdata[3:0], PRE_MIN, PRE_MAX)) begin
                pre_len_ff <= pwdata[3:0];
            end
            if (in_rng4(pwdata[11:8], IFG_MIN, IFG_MAX)) begin
                ifg_min_ff <= pwdata[11:8];
            end
            if (pwdata[31:30] == 2'b00 && pwdata[29:16] >= JMB_MIN
                && pwdata[29:16] <= JMB_MAX) begin
                jumbo_ff <= pwdata[29:16];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mac_ff <= MAC_DEF;
            ip_ff  <= 32'h0;
            vid_ff <= 12'h0;
        end else if (wr && paddr == A_MACLO) begin
            mac_ff[31:0] <= pwdata;
        end else if (wr && paddr == A_MACHI) begin
            mac_ff[47:32] <= pwdata[15:0];
        end else if (wr && paddr == A_IP) begin
            ip_ff <= pwdata;
        end else if (wr && paddr == A_VLAN) begin
            vid_ff <= pwdata[11:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pwd_len_ff <= PWD_MIN;
            pwd_on_ff  <= 1'b0;
            quant_ff   <= QNT_DEF;
        end else if (wr && paddr == A_PWD) begin
            pwd_on_ff <= pwdata[8];
            if (in_rng4(pwdata[3:0], PWD_MIN, PWD_MAX)) begin
                pwd_len_ff <= pwdata[3:0];
            end
        end else if (wr && paddr == A_QUANT && pwdata[15:0] != 16'h0) begin
            quant_ff <= pwdata[15:0];
        end
    end

    // ---- register reads and bus answer ----
    always_comb begin
        rdat = 32'h0;
        hit  = 1'b1;
        if (paddr == A_CTRL) begin
            rdat[C_W-1:0] = ctrl_ff;
        end else if (paddr == A_LINE) begin
            rdat[5:0] = {if_ok_ff, an_mode_ff, 1'b0, rate_ff};
        end else if (paddr == A_RXCFG) begin
            rdat = {2'b00, jumbo_ff, 4'h0, ifg_min_ff, 4'h0, pre_len_ff};
        end else if (paddr == A_MACLO) begin
            rdat = mac_ff[31:0];
        end else if (paddr == A_MACHI) begin
            rdat[15:0] = mac_ff[47:32];
        end else if (paddr == A_IP) begin
            rdat = ip_ff;
        end else if (paddr == A_VLAN) begin
            rdat[11:0] = vid_ff;
        end else if (paddr == A_PWD) begin
            rdat[8:0] = {pwd_on_ff, 4'h0, pwd_len_ff};
        end else if (paddr == A_STAT) begin
            rdat[7:0] = {inband_owned, lp_remote_fault, rx_remote_fault,
                         rx_local_fault, tx_halt, 1'b0, tx_mode};
        end else if (paddr == A_PRE) begin
            rdat[15:0] = pre_cnt_ff;
        end else if (paddr == A_IFG) begin
            rdat[15:0] = ifg_cnt_ff;
        end else if (paddr == A_OVS) begin
            rdat[15:0] = ovs_cnt_ff;
        end else if (paddr == A_QUANT) begin
            rdat[15:0] = quant_ff;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (rd) begin
                prdata <= rdat;
            end
        end
    end

    // ---- receiver checks ----
    epr_rx_check u_chk (
        .clock    (clock),
        .rst      (rst),
        .chk_en   (chk_en),
        .ign_pre  (ctrl_ff[C_IGPRE]),
        .ifg_hide (ctrl_ff[C_IFGF] && rate_ff == R_1G),
        .pre_len  (pre_len_ff),
        .ifg_min  (ifg_min_ff),
        .jumbo    (jumbo_ff),
        .rx       (rx_byte),
        .pre_viol (pre_viol),
        .ifg_viol (ifg_viol),
        .oversize (oversize)
    );

    // reading a counter clears it; a violation in that same cycle still counts
    always_ff @(posedge clock) begin
        if (rst) begin
            pre_cnt_ff <= 16'h0;
            ifg_cnt_ff <= 16'h0;
            ovs_cnt_ff <= 16'h0;
        end else begin
            if (rd && paddr == A_PRE) begin
                pre_cnt_ff <= {15'h0, pre_viol};
            end else if (pre_viol) begin
                pre_cnt_ff <= sat_inc(pre_cnt_ff);
            end
            if (rd && paddr == A_IFG) begin
                ifg_cnt_ff <= {15'h0, ifg_viol};
            end else if (ifg_viol) begin
                ifg_cnt_ff <= sat_inc(ifg_cnt_ff);
            end
            if (rd && paddr == A_OVS) begin
                ovs_cnt_ff <= {15'h0, oversize};
            end else if (oversize) begin
                ovs_cnt_ff <= sat_inc(ovs_cnt_ff);
            end
        end
    end

    // ---- pause: quantum tick divider and remaining quanta ----
    always_ff @(posedge clock) begin
        if (rst) begin
            qtick_ff <= 16'h0;
        end else if (pause_left_ff == 16'h0 || qtick_ff == quant_ff - 16'h1) begin
            qtick_ff <= 16'h0;
        end else begin
            qtick_ff <= qtick_ff + 16'h1;
        end
    end

    // a new pause frame restarts the period; zero quanta releases at once
    always_ff @(posedge clock) begin
        if (rst) begin
            pause_left_ff <= 16'h0;
            tx_halt       <= 1'b0;
        end else if (ctrl_ff[C_PAUSE] && rx_ev.pause) begin
            pause_left_ff <= rx_ev.quanta;
            tx_halt       <= rx_ev.quanta != 16'h0;
        end else if (pause_left_ff != 16'h0 && qtick_ff == quant_ff - 16'h1) begin
            pause_left_ff <= pause_left_ff - 16'h1;
            tx_halt       <= pause_left_ff != 16'h1;
        end else if (!ctrl_ff[C_PAUSE]) begin
            pause_left_ff <= 16'h0;
            tx_halt       <= 1'b0;
        end
    end

    // ---- request answering ----
    // one request per cycle; echo beats ARP beats NS if the parser ever flags two
    always_ff @(posedge clock) begin
        if (rst) begin
            reply <= '0;
        end else begin
            reply.valid <= 1'b0;
            reply.mac   <= mac_ff;
            reply.ip    <= ip_ff;
            if (rx_ev.echo && (ctrl_ff[C_ECHO] || force_rep)) begin
                reply.valid <= 1'b1;
                reply.kind  <= RK_ECHO;
            end else if (rx_ev.arp && (ctrl_ff[C_ARP] || force_rep)) begin
                reply.valid <= 1'b1;
                reply.kind  <= RK_ARP;
            end else if (rx_ev.ns && (ctrl_ff[C_NS] || force_rep)) begin
                reply.valid <= 1'b1;
                reply.kind  <= RK_NS;
            end
        end
    end

    // ---- link fault reaction ----
    always_comb begin
        nxt_mode = ctrl_ff[C_STRM] ? TX_STREAM : TX_IDLE;
        if (ctrl_ff[C_LF] && fast) begin
            case (tx_mode)
                TX_RFAULT, TX_IDLE, TX_STREAM: begin
                    if (rx_local_fault) begin
                        nxt_mode = TX_RFAULT;
                    end else if (rx_remote_fault) begin
                        nxt_mode = TX_IDLE;
                    end
                end
                default: nxt_mode = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_mode <= TX_IDLE;
        end else begin
            tx_mode <= nxt_mode;
        end
    end

    // partner fault only meaningful on electrical or pluggable ports in autoneg
    always_ff @(posedge clock) begin
        if (rst) begin
            lp_remote_fault <= 1'b0;
        end else begin
            lp_remote_fault <= ctrl_ff[C_RFAN] && if_ok_ff && an_mode_ff
                               && an_lp_remote_fault;
        end
    end

    // ---- in-band channel header fields ----
    always_ff @(posedge clock) begin
        if (rst) begin
            inband       <= '0;
            inband_owned <= 1'b0;
        end else begin
            inband_owned    <= ctrl_ff[C_IB];
            inband.en       <= ctrl_ff[C_IB] && ib_ok;
            inband.vlan_en  <= ctrl_ff[C_VLAN];
            inband.tpid     <= IB_TPID;
            inband.pcp      <= IB_PCP;
            inband.dei      <= 1'b0;
            inband.vid      <= vid_ff;
            inband.tos      <= IB_TOS;
            inband.ttl      <= IB_TTL;
            inband.mac      <= ctrl_ff[C_DMAC] ? hw_mac : mac_ff;
            inband.ip       <= ip_ff;
        end
    end
endmodule // epr_port
`default_nettype wire

// file: epr_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module epr_port_props (
    // clock, reset and register bus
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    // receive events and transmit control
    input wire epr_pkg::epr_rx_ev_t   rx_ev,
    input wire logic                  rx_local_fault,
    input wire logic                  rx_remote_fault,
    input wire logic                  tx_halt,
    input wire epr_pkg::epr_txm_t     tx_mode,
    input wire epr_pkg::epr_reply_t   reply
);
    import epr_pkg::*;
    // shadow of the settings, taken from completed bus writes only
    logic [12:0] ctrl_ff;
    logic [2:0]  rate_ff;
    wire logic   wr = psel && penable && pready && pwrite;
    wire logic   lfen = ctrl_ff[C_LF] && (rate_ff >= R_10GL);
    wire logic   ping = ctrl_ff[C_PING];
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= 13'h0;
            rate_ff <= R_1G;
        end else if (wr && paddr == A_CTRL) begin
            ctrl_ff <= pwdata[12:0];
        end else if (wr && paddr == A_LINE) begin
            rate_ff <= pwdata[2:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_pause;
        rx_ev.pause && ctrl_ff[C_PAUSE] && rx_ev.quanta != 16'h0;
    endsequence
    a_pause_halts: assert property (s_pause |=> tx_halt)
        else $error("pause not applied");
    a_echo_reply: assert property (rx_ev.echo && (ctrl_ff[C_ECHO] || ping)
        |=> reply.valid && reply.kind == RK_ECHO) else $error("echo not answered");
    a_arp_reply: assert property (rx_ev.arp && !rx_ev.echo && (ctrl_ff[C_ARP] || ping)
        |=> reply.valid && reply.kind == RK_ARP) else $error("arp not answered");
    a_ns_reply: assert property (rx_ev.ns && !rx_ev.echo && !rx_ev.arp
        && (ctrl_ff[C_NS] || ping) |=> reply.valid && reply.kind == RK_NS)
        else $error("ns not answered");
    a_reply_cause: assert property (reply.valid |-> $past(rx_ev.echo || rx_ev.arp || rx_ev.ns))
        else $error("reply without request");
    a_lf_rfault: assert property (rx_local_fault && lfen |=> tx_mode == TX_RFAULT)
        else $error("remote fault not sent");
    a_rf_idle: assert property (rx_remote_fault && !rx_local_fault && lfen
        |=> tx_mode == TX_IDLE) else $error("idles not sent");
    a_rf_gone: assert property (!(lfen && (rx_local_fault || rx_remote_fault))
        |=> tx_mode == ($past(ctrl_ff[C_STRM]) ? TX_STREAM : TX_IDLE)) else $error("bad resume");
endmodule // epr_port_props
bind epr_port epr_port_props u_props (.*);
`default_nettype wire

// file: epr_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module epr_link_model (
    // clock
    input wire logic              clock,
    // toward the port
    output epr_pkg::epr_rx_ev_t   rx_ev,
    output epr_pkg::epr_rx_byte_t rx_byte,
    output logic                  lf,
    output logic                  rf
);
    import epr_pkg::*;
    initial begin
        rx_ev = '0;
        rx_byte = 3'h1;
        lf = 1'h0;
        rf = 1'h0;
    end
    task automatic ev(input epr_rx_ev_t e);
        @(posedge clock);
        rx_ev <= e;
        @(posedge clock);
        rx_ev <= '0;
    endtask
    task automatic fault(input logic l, input logic r);
        @(posedge clock);
        lf <= l;
        rf <= r;
    endtask
    // line rests on idle bytes after each frame
    task automatic frame(input int np, input int nd, input int ni);
        for (int i = 0; i < np + nd + ni; i++) begin
            @(posedge clock);
            rx_byte <= (i < np) ? 3'h4 : (i < np + nd) ? 3'h2 : 3'h1;
        end
    endtask
endmodule // epr_link_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import epr_pkg::*;
    logic         clock, rst, psel, penable, pwrite, lf, rf, pready, pslverr, tx_halt, err;
    logic [7:0]   paddr, n;
    logic [31:0]  pwdata, prdata, rdat;
    epr_rx_ev_t   ev;
    epr_rx_byte_t rb;
    epr_txm_t     txm;
    epr_reply_t   rep;
    epr_inband_t  ib;
    logic         anrf, tkn, ibo, lprf;
    int           num_errors = 0, comparisons = 0, cyc = 0;
    `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
        $display("unexpected t=%0t got %0h exp %0h", $time, a, b); end end
    epr_link_model u_lp (.clock(clock), .rx_ev(ev), .rx_byte(rb), .lf(lf), .rf(rf));
    epr_port u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_ev(ev), .rx_byte(rb), .rx_local_fault(lf), .rx_remote_fault(rf),
        .hw_mac(48'h0A0B0C0D0E0F), .an_lp_remote_fault(anrf), .inband_taken_other(tkn),
        .tx_halt(tx_halt), .tx_mode(txm), .reply(rep), .inband(ib), .inband_owned(ibo),
        .lp_remote_fault(lprf));
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    task automatic t_regs();
        apb(0, A_RXCFG, 0);
        `CHK(rdat, 32'h233A0C08)
        apb(1, A_RXCFG, 32'h05DF0F02);
        apb(0, A_RXCFG, 0);
        `CHK(rdat, 32'h233A0F08)
        apb(0, 8'hFC, 0);
        `CHK({err, rdat}, 33'h100000000)
        apb(1, A_PWD, 32'h109);
        apb(0, A_PWD, 0);
        `CHK(rdat, 32'h104)
        $display("t_regs done");
    endtask
    task automatic t_reply();
        logic x;
        apb(1, A_MACLO, 32'h89ABCDEF);
        apb(1, A_MACHI, 32'h4567);
        apb(1, A_IP, 32'h0A000001);
        for (int m = 0; m < 2; m++) begin
            apb(1, A_CTRL, m ? 32'h10 : 32'h2);
            for (int k = 0; k < 3; k++) begin
                x = (m == 1 || k == 0);
                u_lp.ev(epr_rx_ev_t'(20'(4 >> k)));
                @(posedge clock);
                `CHK(rep.valid, x)
                if (x) `CHK({rep.kind, rep.mac, rep.ip}, {2'(k), 48'h456789ABCDEF, 32'h0A000001})
            end
        end
        $display("t_reply done");
    endtask
    task automatic t_pause();
        apb(1, A_QUANT, 2);
        apb(1, A_CTRL, 1);
        u_lp.ev(epr_rx_ev_t'({1'h1, 16'h3, 3'h0}));
        n = 8'h0;
        repeat (10) begin
            @(posedge clock);
            n += tx_halt;
        end
        `CHK(n, 8'h6)
        $display("t_pause done");
    endtask
    task automatic t_fault();
        apb(1, A_LINE, 3);
        apb(1, A_CTRL, 32'h820);
        for (int k = 0; k < 4; k++) begin
            if (k == 3) apb(1, A_LINE, 1);
            u_lp.fault(k == 0 || k == 3, k == 1);
            repeat (2) @(posedge clock);
            `CHK(txm, k == 0 ? TX_RFAULT : k == 1 ? TX_IDLE : TX_STREAM)
        end
        u_lp.fault(0, 0);
        $display("t_fault done");
    endtask
    task automatic t_rxchk();
        apb(1, A_LINE, 2);
        apb(1, A_CTRL, 0);
        u_lp.frame(7, 10, 20);
        u_lp.frame(8, 10, 5);
        u_lp.frame(8, 10, 12);
        apb(0, A_PRE, 0);
        `CHK(rdat, 32'h1)
        apb(0, A_IFG, 0);
        `CHK(rdat, 32'h1)
        apb(1, A_CTRL, 32'hC0);
        u_lp.frame(5, 10, 3);
        u_lp.frame(5, 10, 12);
        apb(1, A_CTRL, 0);
        apb(1, A_LINE, 5);
        u_lp.frame(5, 10, 12);
        apb(0, A_PRE, 0);
        `CHK(rdat, 32'h0)
        apb(0, A_IFG, 0);
        `CHK(rdat, 32'h0)
        apb(1, A_RXCFG, 32'h05EF0C08);
        u_lp.frame(8, 1519, 3);
        u_lp.frame(8, 1520, 3);
        apb(0, A_OVS, 0);
        `CHK(rdat, 32'h1)
        $display("t_rxchk done");
    endtask
    task automatic t_inband();
        anrf <= 1'h1;
        apb(1, A_LINE, 32'h32);
        apb(1, A_VLAN, 32'h123);
        apb(1, A_CTRL, 32'h1700);
        repeat (3) @(posedge clock);
        `CHK({ibo, lprf, ib.en, ib.vlan_en, ib.tpid}, 20'hF8100)
        `CHK({ib.pcp, ib.dei, ib.vid, ib.tos, ib.ttl}, 32'h01230014)
        `CHK(ib.mac, 48'h0A0B0C0D0E0F)
        tkn <= 1'h1;
        repeat (3) @(posedge clock);
        `CHK({ibo, ib.en}, 2'h0)
        $display("t_inband done");
    endtask
    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        anrf = 1'h0;
        tkn = 1'h0;
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        t_regs();
        t_reply();
        t_pause();
        t_fault();
        t_rxchk();
        t_inband();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
